// [src/asram_consts.vh]
// Constants for the asynchronous static memory port controller
// Assumes a 100 MHz system clock; counts derive from nanosecond figures
`ifndef ASRAM_CONSTS_VH
`define ASRAM_CONSTS_VH
`define ASRAM_CLK_PERIOD_NS   10
`define ASRAM_CYCLE_NS        70
`define ASRAM_CYCLE_CYC       ((`ASRAM_CYCLE_NS + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_ADDR_W          19
`define ASRAM_DATA_W          16
`define ASRAM_CNT_W           8
`define ASRAM_CNT_ONE         8'h01
`define ASRAM_CNT_ZERO        8'h00
`define ASRAM_LANE_LO         0
`define ASRAM_LANE_HI         1
`define ASRAM_BYTE_W          8
`define ASRAM_HI_MSB          15
`define ASRAM_HI_LSB          8
`define ASRAM_LO_MSB          7
`define ASRAM_LO_LSB          0
`define ASRAM_BYTE_ZERO       8'h00
`define ASRAM_DATA_ZERO       16'h0000
`define ASRAM_ADDR_ZERO       19'h00000
`define ASRAM_LANES_NONE      2'h0
`endif

// [src/asram_ctrl.v]
// Host-side controller driving an asynchronous 16-bit static memory port
// Assumes a 100 MHz clock, pin inputs synchronous to it, one request at a time
`timescale 1ns/1ps
`default_nettype none
`include "asram_consts.vh"

// How it works
// - Each cycle lasts at least access time
// - High-select retention holds low select firm
// - Deselect before retention, zero delay allowed
// - Stay deselected one cycle after retention
module asram_ctrl #(
  parameter CYCLE_CYC = `ASRAM_CYCLE_CYC
) (
  input  wire                       clk_i,
  input  wire                       nrst_i,
  input  wire                       req_i,
  input  wire                       req_write_i,
  input  wire [1:0]                 req_lanes_i,
  input  wire [`ASRAM_ADDR_W-1:0]   req_addr_i,
  input  wire [`ASRAM_DATA_W-1:0]   req_wdata_i,
  input  wire                       retain_i,
  output wire                       ready_o,
  output reg                        done_o,
  output reg  [`ASRAM_DATA_W-1:0]   rdata_o,
  output wire                       retained_o,
  output reg  [`ASRAM_ADDR_W-1:0]   word_address_o,
  output reg                        chip_select_low_n_o,
  output reg                        chip_select_high_o,
  output reg                        write_strobe_n_o,
  output reg                        output_gate_n_o,
  output reg                        low_byte_select_n_o,
  output reg                        high_byte_select_n_o,
  input  wire [`ASRAM_DATA_W-1:0]   shared_data_bus_i,
  output reg  [`ASRAM_DATA_W-1:0]   shared_data_bus_o,
  output reg  [`ASRAM_DATA_W-1:0]   shared_data_bus_oe_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_IDLE    = 5'h01;
  localparam [4:0] ST_READ    = 5'h02;
  localparam [4:0] ST_WRITE   = 5'h04;
  localparam [4:0] ST_RETAIN  = 5'h08;
  localparam [4:0] ST_RECOVER = 5'h10;


  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  reg  [4:0]               state;
  reg  [`ASRAM_CNT_W-1:0]  count;
  reg  [1:0]               lanes;
  wire [`ASRAM_CNT_W-1:0]  cycle_cnt;
  wire                     in_idle;
  wire                     in_read;
  wire                     in_write;
  wire                     in_retain;
  wire                     in_recover;
  wire                     lanes_any;
  wire                     take;
  wire                     count_last;
  wire                     counting;
  wire                     access_end;
  wire [`ASRAM_DATA_W-1:0] req_lane_mask;
  wire [`ASRAM_BYTE_W-1:0] read_hi;
  wire [`ASRAM_BYTE_W-1:0] read_lo;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  assign cycle_cnt     = CYCLE_CYC[`ASRAM_CNT_W-1:0];
  assign in_idle       = (state == ST_IDLE);
  assign in_read       = (state == ST_READ);
  assign in_write      = (state == ST_WRITE);
  assign in_retain     = (state == ST_RETAIN);
  assign in_recover    = (state == ST_RECOVER);
  assign lanes_any     = (req_lanes_i != `ASRAM_LANES_NONE);
  assign take          = in_idle && !retain_i && req_i && lanes_any;
  assign count_last    = (count == `ASRAM_CNT_ONE);
  assign counting      = (in_read || in_write || in_recover) && !count_last;
  assign access_end    = (in_read || in_write) && count_last;
  assign req_lane_mask = {{`ASRAM_BYTE_W{req_lanes_i[`ASRAM_LANE_HI]}},
                          {`ASRAM_BYTE_W{req_lanes_i[`ASRAM_LANE_LO]}}};
  assign read_hi       = lanes[`ASRAM_LANE_HI] ? shared_data_bus_i[`ASRAM_HI_MSB:`ASRAM_HI_LSB] : `ASRAM_BYTE_ZERO;
  assign read_lo       = lanes[`ASRAM_LANE_LO] ? shared_data_bus_i[`ASRAM_LO_MSB:`ASRAM_LO_LSB] : `ASRAM_BYTE_ZERO;

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign ready_o    = in_idle && !retain_i;
  assign retained_o = in_retain;

  // ----------------------------------------
  // Cycle counter
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= `ASRAM_CNT_ZERO;
    end else if (take) begin
      // Every access holds its pins for a full cycle
      count <= cycle_cnt;
    end else if (in_retain && !retain_i) begin
      count <= cycle_cnt;
    end else if (counting) begin
      count <= count - `ASRAM_CNT_ONE;
    end
  end

  // ----------------------------------------
  // Read capture and completion
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o  <= 1'h0;
      rdata_o <= `ASRAM_DATA_ZERO;
    end else begin
      done_o <= access_end;
      if (in_read && count_last) begin
        // Unselected lanes read as zero
        rdata_o <= {read_hi, read_lo};
      end
    end
  end

  // ----------------------------------------
  // Sequencer and pins
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state                <= ST_IDLE;
      lanes                <= `ASRAM_LANES_NONE;
      word_address_o       <= `ASRAM_ADDR_ZERO;
      chip_select_low_n_o  <= 1'h1;
      chip_select_high_o   <= 1'h0;
      write_strobe_n_o     <= 1'h1;
      output_gate_n_o      <= 1'h1;
      low_byte_select_n_o  <= 1'h1;
      high_byte_select_n_o <= 1'h1;
      shared_data_bus_o    <= `ASRAM_DATA_ZERO;
      shared_data_bus_oe_o <= `ASRAM_DATA_ZERO;
    end else begin
      case (state)
        ST_IDLE: begin
          // Standby with low and byte selects off, high select on, bus released
          chip_select_low_n_o  <= 1'h1;
          chip_select_high_o   <= 1'h1;
          write_strobe_n_o     <= 1'h1;
          output_gate_n_o      <= 1'h1;
          low_byte_select_n_o  <= 1'h1;
          high_byte_select_n_o <= 1'h1;
          shared_data_bus_oe_o <= `ASRAM_DATA_ZERO;
          if (retain_i) begin
            // Deselected already, retention may follow at once
            chip_select_high_o <= 1'h0;
            state              <= ST_RETAIN;
          end else if (take) begin
            word_address_o       <= req_addr_i;
            lanes                <= req_lanes_i;
            chip_select_low_n_o  <= 1'h0;
            chip_select_high_o   <= 1'h1;
            low_byte_select_n_o  <= !req_lanes_i[`ASRAM_LANE_LO];
            high_byte_select_n_o <= !req_lanes_i[`ASRAM_LANE_HI];
            if (req_write_i) begin
              write_strobe_n_o     <= 1'h0;
              shared_data_bus_o    <= req_wdata_i;
              shared_data_bus_oe_o <= req_lane_mask;
              state                <= ST_WRITE;
            end else begin
              // Bus released at the same edge that opens the gate
              output_gate_n_o      <= 1'h0;
              shared_data_bus_oe_o <= `ASRAM_DATA_ZERO;
              state                <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (count_last) begin
            output_gate_n_o      <= 1'h1;
            chip_select_low_n_o  <= 1'h1;
            low_byte_select_n_o  <= 1'h1;
            high_byte_select_n_o <= 1'h1;
            state                <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (count_last) begin
            // Strobe ends the write; data held one more cycle
            write_strobe_n_o     <= 1'h1;
            chip_select_low_n_o  <= 1'h1;
            low_byte_select_n_o  <= 1'h1;
            high_byte_select_n_o <= 1'h1;
            state                <= ST_IDLE;
          end
        end
        ST_RETAIN: begin
          if (!retain_i) begin
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          // Deselected for one full read cycle
          chip_select_high_o <= 1'h1;
          if (count_last) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // asram_ctrl
`default_nettype wire

// [testbench/asram_mem_model.sv]
// Behavioural 16-bit static memory facing asram_ctrl
// Assumes pins from asram_ctrl and the resolved bus level
`timescale 1ns/1ps
`default_nettype none
module asram_mem_model (
  input  wire logic [18:0] addr_i,
  input  wire logic        cs_low_n_i,
  input  wire logic        cs_high_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        lb_n_i,
  input  wire logic        hb_n_i,
  input  wire logic [15:0] dq_i,
  output wire logic [15:0] dq_o,
  output wire logic [15:0] dq_oe_o
);
  logic [15:0] mem [0:524287];
  wire sel = !cs_low_n_i && cs_high_i && !(lb_n_i && hb_n_i);
  wire [15:0] ln = {{8{!hb_n_i}}, {8{!lb_n_i}}};
  wire act = sel && !we_n_i;
  assign dq_o = mem[addr_i];
  assign dq_oe_o = (sel && we_n_i && !oe_n_i) ? ln : 16'h0000;
  // Level store while the overlap lasts; no race with the closing edge
  always @(act, addr_i, dq_i, ln) if (act) mem[addr_i] = (mem[addr_i] & ~ln) | (dq_i & ln);
endmodule  // asram_mem_model
`default_nettype wire

// [testbench/asram_ctrl_sva.sv]
// Pin checker for asram_ctrl
// Assumes binding to every asram_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module asram_ctrl_sva (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        req_i,
  input wire logic        req_write_i,
  input wire logic [1:0]  req_lanes_i,
  input wire logic        ready_o,
  input wire logic        done_o,
  input wire logic        retained_o,
  input wire logic [18:0] word_address_o,
  input wire logic        chip_select_low_n_o,
  input wire logic        chip_select_high_o,
  input wire logic        write_strobe_n_o,
  input wire logic        output_gate_n_o,
  input wire logic        low_byte_select_n_o,
  input wire logic        high_byte_select_n_o,
  input wire logic [15:0] shared_data_bus_o,
  input wire logic [15:0] shared_data_bus_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence take_s;
    req_i && ready_o && req_lanes_i != 2'h0;
  endsequence
  sequence hold_s;
    (!chip_select_low_n_o && chip_select_high_o)[*6];
  endsequence
  idle_quiet_a: assert property (ready_o |-> write_strobe_n_o && output_gate_n_o)
    else $error("idle pins active");
  no_fight_a: assert property (!output_gate_n_o |-> shared_data_bus_oe_o == 16'h0000)
    else $error("bus driven during read");
  read_pins_a: assert property (take_s and !req_write_i |=> !output_gate_n_o && write_strobe_n_o
    && {high_byte_select_n_o, low_byte_select_n_o} == ~$past(req_lanes_i)) else $error("read pins wrong");
  write_pins_a: assert property (take_s and req_write_i |=> !write_strobe_n_o && shared_data_bus_oe_o != 0
    && {high_byte_select_n_o, low_byte_select_n_o} == ~$past(req_lanes_i)) else $error("write pins wrong");
  cycle_len_a: assert property (take_s |=> hold_s ##[1:2] done_o)
    else $error("access too short");
  done_once_a: assert property (done_o |=> !done_o)
    else $error("done not a pulse");
  wr_stable_a: assert property (!write_strobe_n_o && !$past(write_strobe_n_o)
    |-> $stable(word_address_o) && $stable(shared_data_bus_o)) else $error("write moved");
  retain_pins_a: assert property (retained_o |-> !chip_select_high_o && chip_select_low_n_o)
    else $error("retention pins wrong");
  recover_len_a: assert property ($fell(retained_o) |-> (!ready_o && chip_select_low_n_o)[*6])
    else $error("recovery too short");
endmodule  // asram_ctrl_sva
bind asram_ctrl asram_ctrl_sva u_asram_ctrl_sva (.*);
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for asram_ctrl with a memory model
// Assumes asram_ctrl default cycle length
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 0, nrst_i = 0, req_i = 0, req_write_i = 0, retain_i = 0;
  logic [1:0] req_lanes_i = 0;
  logic [18:0] req_addr_i = 0;
  logic [15:0] req_wdata_i = 0;
  wire ready_o, done_o, retained_o, cs_l, cs_h, we_n, oe_n, lb_n, hb_n;
  wire [15:0] rdata_o, d_o, d_oe, m_q, m_oe, bus;
  wire [18:0] addr;
  int mismatches = 0, n_tests = 0, cyc = 0, k;
  always #5 clk_i = ~clk_i;
  assign bus = (d_o & d_oe) | (m_q & m_oe) | (~(d_oe | m_oe) & (16'h5a5a ^ {16{cyc[0]}}));
  asram_ctrl u_asram_ctrl (.clk_i, .nrst_i, .req_i, .req_write_i, .req_lanes_i, .req_addr_i, .req_wdata_i,
    .retain_i, .ready_o, .done_o, .rdata_o, .retained_o, .word_address_o(addr), .chip_select_low_n_o(cs_l),
    .chip_select_high_o(cs_h), .write_strobe_n_o(we_n), .output_gate_n_o(oe_n), .low_byte_select_n_o(lb_n),
    .high_byte_select_n_o(hb_n), .shared_data_bus_i(bus), .shared_data_bus_o(d_o), .shared_data_bus_oe_o(d_oe));
  asram_mem_model u_asram_mem_model (.addr_i(addr), .cs_low_n_i(cs_l), .cs_high_i(cs_h), .we_n_i(we_n),
    .oe_n_i(oe_n), .lb_n_i(lb_n), .hb_n_i(hb_n), .dq_i(bus), .dq_o(m_q), .dq_oe_o(m_oe));
  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] ln, input logic [18:0] a, input logic [15:0] d);
    do @(posedge clk_i); while (ready_o !== 1'b1);
    #1 {req_i, req_write_i, req_lanes_i, req_addr_i, req_wdata_i} = {1'b1, w, ln, a, d};
    @(posedge clk_i);
    #1 req_i = 0;
    for (k = 0; k < 12 && done_o !== 1'b1; k++) @(posedge clk_i) #1;
    chk({15'h0, done_o}, {15'h0, ln != 2'h0});
  endtask
  task automatic t_word;
    acc(1, 3, 19'h7ffff, 16'hbeef);
    acc(1, 3, 0, 16'h1234);
    acc(0, 3, 19'h7ffff, 0); chk(rdata_o, 16'hbeef);
    acc(0, 3, 0, 0); chk(rdata_o, 16'h1234);
  endtask
  task automatic t_bytes;
    acc(1, 3, 5, 16'h0000);
    acc(1, 1, 5, 16'hff12);
    acc(1, 2, 5, 16'h34ff);
    acc(0, 3, 5, 0); chk(rdata_o, 16'h3412);
    acc(0, 1, 5, 0); chk(rdata_o, 16'h0012);
    acc(0, 2, 5, 0); chk(rdata_o, 16'h3400);
    acc(1, 0, 5, 16'hffff);
    acc(0, 3, 5, 0); chk(rdata_o, 16'h3412);
  endtask
  task automatic t_retain;
    @(posedge clk_i) #1 retain_i = 1;
    repeat (2) @(posedge clk_i);
    #1 chk({13'h0, retained_o, cs_h, ready_o}, 16'h0004);
    retain_i = 0;
    for (k = 0; k < 30 && ready_o !== 1'b1; k++) @(posedge clk_i) #1;
    chk({15'h0, k >= 7}, 16'h0001);
    acc(0, 3, 0, 0); chk(rdata_o, 16'h1234);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 nrst_i = 1;
    t_word;
    t_bytes;
    t_retain;
    tally_and_finish;
  end
endmodule  // tb_top
`default_nettype wire
